// ===== atbt_advanced_timer_time_base_test.sv
// Self-checking bench for the timer time base core: counting, events, byte access.
// Assumes the constants header, the package and the core are compiled first.
module atbt_advanced_timer_time_base_test
  import atbt_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LIM = 2000;

  logic        ref_clk, rst, counterRunEnable, reloadPreloadEnable, updateInhibit;
  logic        updateRequestSourceSelect, forceUpdateBit, triggerEvent, updateFlagClear;
  logic        wrEn, rdEn, internalCountEnable_r, dividedCounterClock_r, overflow_r;
  logic        updateEvent_r, updateFlag_r;
  logic [7:0]  wrData, rdData_r;
  logic [15:0] counterValue_r;
  atbt_sel_t   regSel;
  int          failures, nChecks;

  // Device under test
  atbt_core DUT (
    .ref_clk, .rst, .counterRunEnable, .reloadPreloadEnable, .updateInhibit,
    .updateRequestSourceSelect, .forceUpdateBit, .triggerEvent, .updateFlagClear,
    .wrEn, .rdEn, .regSel, .wrData, .rdData_r, .counterValue_r, .internalCountEnable_r,
    .dividedCounterClock_r, .overflow_r, .updateEvent_r, .updateFlag_r
  );

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Verdict and end of run
  task automatic wrap_up();
    if (failures == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compare of multi-bit values
  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare of single flags
  task automatic chkBit(input logic got, input logic exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Byte write; strobe stays up for back-to-back accesses
  task automatic wr(input atbt_sel_t sel, input logic [7:0] d);
    rdEn = 1'b0;
    wrEn = 1'b1;
    regSel = sel;
    wrData = d;
    @(negedge ref_clk);
  endtask

  // Byte read; data lands one cycle after the strobe edge
  task automatic rd(input atbt_sel_t sel, input logic [7:0] exp);
    wrEn = 1'b0;
    rdEn = 1'b1;
    regSel = sel;
    @(negedge ref_clk);
    chkVal({8'h00, rdData_r}, {8'h00, exp});
  endtask

  // Drop both strobes without waiting
  task automatic rel();
    wrEn = 1'b0;
    rdEn = 1'b0;
    regSel = ATBT_NONE;
  endtask

  // One-cycle pulse: 0 forced update, 1 trigger, else flag clear
  task automatic pulse(input int which);
    case (which)
      0: forceUpdateBit = 1'b1;
      1: triggerEvent = 1'b1;
      default: updateFlagClear = 1'b1;
    endcase
    @(negedge ref_clk);
    forceUpdateBit = 1'b0;
    triggerEvent = 1'b0;
    updateFlagClear = 1'b0;
  endtask

  // Bounded wait for the next overflow pulse, returns cycles spent
  task automatic waitOvf(output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (overflow_r !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      failures++;
      wrap_up();
    end
  endtask

  // Full period between two overflows and the state at the wrap
  task automatic measure(input int exp, input logic upd);
    int n;
    waitOvf(n);
    waitOvf(n);
    chkVal(16'(n), 16'(exp));
    chkBit(updateEvent_r, upd);
    chkVal(counterValue_r, 16'h0000);
    chkBit(dividedCounterClock_r, 1'b1);
  endtask

  // Reset state and byte-wise register access with the counter stopped
  task automatic scRegs();
    chkVal(counterValue_r, 16'h0000);
    chkBit(internalCountEnable_r, 1'b0);
    chkBit(updateFlag_r, 1'b0);
    rd(ATBT_ARRH, 8'hFF);
    wr(ATBT_CNTH, 8'h12);
    wr(ATBT_CNTL, 8'h34);
    rd(ATBT_CNTH, 8'h12);
    chkVal(counterValue_r, 16'h1234);
    wr(ATBT_CNTL, 8'h56);
    rd(ATBT_CNTL, 8'h34);
    rd(ATBT_CNTL, 8'h56);
    chkVal(counterValue_r, 16'h1256);
    rd(ATBT_CNTH, 8'h12);
    rd(ATBT_CNTL, 8'h56);
    wr(ATBT_PSCH, 8'h0A);
    wr(ATBT_PSCL, 8'h0B);
    rd(ATBT_PSCH, 8'h0A);
    rd(ATBT_PSCL, 8'h0B);
    wr(ATBT_RCR, 8'h5A);
    rd(ATBT_RCR, 8'h5A);
    rd(ATBT_NONE, 8'h00);
    rel();
    @(negedge ref_clk);
  endtask

  // Forced update loads the divider, direct reload write, then run
  task automatic scBase();
    wr(ATBT_PSCH, 8'h00);
    wr(ATBT_PSCL, 8'h01);
    pulse(0);
    chkBit(updateEvent_r, 1'b1);
    chkVal(counterValue_r, 16'h0000);
    wr(ATBT_ARRH, 8'h00);
    wr(ATBT_ARRL, 8'h03);
    chkBit(updateFlag_r, 1'b1);
    rel();
    counterRunEnable = 1'b1;
    @(negedge ref_clk);
    chkBit(internalCountEnable_r, 1'b1);
    measure(8, 1'b1);
  endtask

  // Inhibited wraps keep the old divider and leave the flag alone
  task automatic scInhibit();
    int n;
    updateInhibit = 1'b1;
    waitOvf(n);
    pulse(2);
    wr(ATBT_PSCH, 8'h00);
    wr(ATBT_PSCL, 8'h02);
    rel();
    measure(8, 1'b0);
    chkBit(updateFlag_r, 1'b0);
    updateInhibit = 1'b0;
    measure(12, 1'b1);
    chkBit(updateFlag_r, 1'b1);
  endtask

  // Preloaded reload value waits for the wrap; word assembled high byte first
  task automatic scPreload();
    int n;
    reloadPreloadEnable = 1'b1;
    waitOvf(n);
    wr(ATBT_ARRH, 8'h00);
    wr(ATBT_ARRL, 8'h05);
    rel();
    waitOvf(n);
    chkVal(16'(n + 2), 16'h000C);
    measure(18, 1'b1);
    wr(ATBT_ARRH, 8'h01);
    rel();
    measure(18, 1'b1);
    wr(ATBT_ARRL, 8'h00);
    rel();
    measure(771, 1'b1);
  endtask

  // Forced and triggered updates with flag suppression and inhibit
  task automatic scEvents();
    int n;
    waitOvf(n);
    pulse(2);
    updateRequestSourceSelect = 1'b1;
    wr(ATBT_CNTL, 8'h50);
    rel();
    pulse(0);
    chkBit(updateEvent_r, 1'b1);
    chkVal(counterValue_r, 16'h0000);
    @(negedge ref_clk);
    chkBit(updateFlag_r, 1'b0);
    pulse(1);
    chkBit(updateEvent_r, 1'b1);
    @(negedge ref_clk);
    chkBit(updateFlag_r, 1'b1);
    updateInhibit = 1'b1;
    pulse(2);
    wr(ATBT_CNTL, 8'h50);
    rel();
    pulse(0);
    chkBit(updateEvent_r, 1'b0);
    chkVal(counterValue_r, 16'h0000);
    chkBit(updateFlag_r, 1'b0);
    updateInhibit = 1'b0;
    updateRequestSourceSelect = 1'b0;
  endtask

  // Clearing the run bit stops counting one cycle later
  task automatic scStop();
    logic [15:0] w;
    counterRunEnable = 1'b0;
    @(negedge ref_clk);
    chkBit(internalCountEnable_r, 1'b0);
    @(negedge ref_clk);
    w = counterValue_r;
    repeat (8) @(negedge ref_clk);
    chkVal(counterValue_r, w);
    chkBit(dividedCounterClock_r, 1'b0);
  endtask

  // Main sequence: reset for four cycles, then the scenarios
  initial begin
    failures = 0;
    nChecks = 0;
    rst = 1'b1;
    counterRunEnable = 1'b0;
    reloadPreloadEnable = 1'b0;
    updateInhibit = 1'b0;
    updateRequestSourceSelect = 1'b0;
    forceUpdateBit = 1'b0;
    triggerEvent = 1'b0;
    updateFlagClear = 1'b0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    regSel = ATBT_NONE;
    wrData = 8'h00;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    scRegs();
    scBase();
    scInhibit();
    scPreload();
    scEvents();
    scStop();
    wrap_up();
  end
endmodule // atbt_advanced_timer_time_base_test

// ===== atbt_consts.svh
// Constants of the timer time base: access selects, reset values, widths.
// Assumes inclusion by the package and by every design module of the block.
`ifndef ATBT_CONSTS_SVH
`define ATBT_CONSTS_SVH

// Byte access selects on the register port
`define ATBT_SEL_CNTH 3'h0
`define ATBT_SEL_CNTL 3'h1
`define ATBT_SEL_PSCH 3'h2
`define ATBT_SEL_PSCL 3'h3
`define ATBT_SEL_ARRH 3'h4
`define ATBT_SEL_ARRL 3'h5
`define ATBT_SEL_RCR  3'h6

// Widths
`define ATBT_CNT_W  16
`define ATBT_BYTE_W 8

// Reset values
`define ATBT_CNT_RST  16'h0000
`define ATBT_PSC_RST  16'h0000
`define ATBT_ARR_RST  16'hFFFF
`define ATBT_RCR_RST  8'h00
`define ATBT_BYTE_RST 8'h00

// Byte field positions inside a 16-bit value
`define ATBT_HI_MSB 15
`define ATBT_HI_LSB 8
`define ATBT_LO_MSB 7
`define ATBT_LO_LSB 0

`endif

// ===== atbt_core.sv
// Time base of a 16-bit advanced control timer: counter, prescaler, reload.
// Assumes all controls and byte strobes come from logic on ref_clk.
//
// Notes on behaviour
// - Counter clock is input clock over prescaler+1.
// - Counter, prescaler, reload, repetition are read/write.
// - Preload on: reload shadow changes at update.
// - Preload off: reload write reaches shadow immediately.
// - Update from wrap, forced update or trigger.
// - Update inhibit suppresses every update event.
// - Count enable follows run bit one cycle later.
// - Counter byte writes act directly, even running.
// - High byte read latches low byte for later.
// - Reload high write blocks transfer until low.
// - Prescaler word loads when low byte written.
// - New prescaler applies after next update event.
// - Prescaler reads return held high byte and preload low byte.
// - Up count to reload value, wrap, overflow.
// - Forced update restarts counter and prescaler.
// - Source select hides flag for forced update.
// - Update copies preloads and sets the flag.
`include "atbt_consts.svh"

module atbt_core
  import atbt_pkg::*;
#(
  parameter int CNT_W = `ATBT_CNT_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             counterRunEnable,
  input  wire logic             reloadPreloadEnable,
  input  wire logic             updateInhibit,
  input  wire logic             updateRequestSourceSelect,
  input  wire logic             forceUpdateBit,
  input  wire logic             triggerEvent,
  input  wire logic             updateFlagClear,
  input  wire logic             wrEn,
  input  wire logic             rdEn,
  input  wire atbt_sel_t        regSel,
  input  wire logic [7:0]       wrData,
  output logic      [7:0]       rdData_r,
  output logic      [CNT_W-1:0] counterValue_r,
  output logic                  internalCountEnable_r,
  output logic                  dividedCounterClock_r,
  output logic                  overflow_r,
  output logic                  updateEvent_r,
  output logic                  updateFlag_r
);

  if (CNT_W != 16) begin : gWidthCheck
    $error("atbt_core: byte access logic serves a 16-bit counter only");
  end

  logic [15:0] counter_nxt;
  logic [7:0]  lowLatch_r;
  logic        latchHeld_r;
  logic [7:0]  pscHold_r;
  logic [15:0] pscPreload_r;
  logic [7:0]  repCount_r;
  logic [7:0]  rd_nxt;
  logic        cntTick;
  logic [15:0] pscDivision;
  logic [15:0] arrPreload;
  logic [15:0] arrShadow;
  logic        arrBlocked;

  // Byte strobe decode
  logic wrCntH;
  logic wrCntL;
  logic wrPscH;
  logic wrPscL;
  logic wrArrH;
  logic wrArrL;
  logic wrRcr;
  logic rdCntH;
  logic rdCntL;
  assign wrCntH = wrEn && (regSel == ATBT_CNTH);
  assign wrCntL = wrEn && (regSel == ATBT_CNTL);
  assign wrPscH = wrEn && (regSel == ATBT_PSCH);
  assign wrPscL = wrEn && (regSel == ATBT_PSCL);
  assign wrArrH = wrEn && (regSel == ATBT_ARRH);
  assign wrArrL = wrEn && (regSel == ATBT_ARRL);
  assign wrRcr  = wrEn && (regSel == ATBT_RCR);
  assign rdCntH = rdEn && (regSel == ATBT_CNTH);
  assign rdCntL = rdEn && (regSel == ATBT_CNTL);

  // Update sources, inhibit and flag qualification
  logic forceRestart;
  logic wrapHit;
  logic updateNow;
  logic flagSet;
  assign forceRestart = forceUpdateBit || triggerEvent;
  assign wrapHit      = cntTick && (counterValue_r == arrShadow);
  assign updateNow    = !updateInhibit && (wrapHit || forceRestart);
  assign flagSet      = updateNow &&
                        (wrapHit || triggerEvent || !updateRequestSourceSelect);

  // Counter next value: restart, then direct writes, then counting
  assign counter_nxt =
    forceRestart ? `ATBT_CNT_RST :
    wrCntH       ? {wrData, counterValue_r[`ATBT_LO_MSB:`ATBT_LO_LSB]} :
    wrCntL       ? {counterValue_r[`ATBT_HI_MSB:`ATBT_HI_LSB], wrData} :
    wrapHit      ? `ATBT_CNT_RST :
    cntTick      ? counterValue_r + 16'h0001 : counterValue_r;

  // Read data selection; prescaler bytes come from the preload side
  assign rd_nxt =
    (regSel == ATBT_CNTH) ? counterValue_r[`ATBT_HI_MSB:`ATBT_HI_LSB] :
    (regSel == ATBT_CNTL) ? (latchHeld_r ? lowLatch_r
                                         : counterValue_r[`ATBT_LO_MSB:`ATBT_LO_LSB]) :
    (regSel == ATBT_PSCH) ? pscHold_r :
    (regSel == ATBT_PSCL) ? pscPreload_r[`ATBT_LO_MSB:`ATBT_LO_LSB] :
    (regSel == ATBT_ARRH) ? arrPreload[`ATBT_HI_MSB:`ATBT_HI_LSB] :
    (regSel == ATBT_ARRL) ? arrPreload[`ATBT_LO_MSB:`ATBT_LO_LSB] :
    (regSel == ATBT_RCR)  ? repCount_r : `ATBT_BYTE_RST;

  // Divided clock generator
  atbt_prescaler #(
    .PSC_W (16)
  ) uPrescaler (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .countEnable   (internalCountEnable_r),
    .restart       (forceRestart),
    .reloadBuffer  (updateNow),
    .preloadValue  (pscPreload_r),
    .counterTick   (cntTick),
    .divisionValue (pscDivision)
  );

  // Auto-reload preload and shadow
  atbt_reload uReload (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .preloadEnable   (reloadPreloadEnable),
    .writeHigh       (wrArrH),
    .writeLow        (wrArrL),
    .wrData          (wrData),
    .updateEvent     (updateNow),
    .preloadValue    (arrPreload),
    .shadowValue     (arrShadow),
    .transferBlocked (arrBlocked)
  );

  // Count enable trails the run bit by one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) internalCountEnable_r <= 1'b0;
    else     internalCountEnable_r <= counterRunEnable;
  end

  // Counter register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) counterValue_r <= `ATBT_CNT_RST;
    else     counterValue_r <= counter_nxt;
  end

  // Low byte latch armed by a high byte read, released by the low read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lowLatch_r  <= `ATBT_BYTE_RST;
      latchHeld_r <= 1'b0;
    end else if (rdCntH) begin
      lowLatch_r  <= counterValue_r[`ATBT_LO_MSB:`ATBT_LO_LSB];
      latchHeld_r <= 1'b1;
    end else if (rdCntL) begin
      latchHeld_r <= 1'b0;
    end
  end

  // Prescaler preload: high byte held, word taken on the low byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)         pscHold_r <= 8'(`ATBT_PSC_RST >> `ATBT_HI_LSB);
    else if (wrPscH) pscHold_r <= wrData;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)         pscPreload_r <= `ATBT_PSC_RST;
    else if (wrPscL) pscPreload_r <= {pscHold_r, wrData};
  end

  // Repetition count, stored for software only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)        repCount_r <= `ATBT_RCR_RST;
    else if (wrRcr) repCount_r <= wrData;
  end

  // Read data register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)       rdData_r <= `ATBT_BYTE_RST;
    else if (rdEn) rdData_r <= rd_nxt;
  end

  // Registered event outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dividedCounterClock_r <= 1'b0;
      overflow_r            <= 1'b0;
      updateEvent_r         <= 1'b0;
    end else begin
      dividedCounterClock_r <= cntTick;
      overflow_r            <= wrapHit;
      updateEvent_r         <= updateNow;
    end
  end

  // Sticky update flag; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)                  updateFlag_r <= 1'b0;
    else if (flagSet)         updateFlag_r <= 1'b1;
    else if (updateFlagClear) updateFlag_r <= 1'b0;
  end

  // Checks
  default clocking cbC @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence sHighRead;
    rdCntH;
  endsequence

  sequence sLowReadLater;
    rdCntL;
  endsequence

  run_enable_delay_a: assert property (
    ##1 internalCountEnable_r == $past(counterRunEnable))
    else $error("Count enable does not trail the run bit by one cycle");

  inhibit_no_update_a: assert property (updateInhibit |=> !updateEvent_r)
    else $error("Update event raised while inhibited");

  wrap_to_zero_a: assert property (
    wrapHit && !forceRestart && !wrCntH && !wrCntL
    |=> counterValue_r == 16'h0000 && overflow_r)
    else $error("Counter did not wrap to zero with overflow");

  count_step_a: assert property (
    cntTick && !wrapHit && !forceRestart && !wrCntH && !wrCntL
    |=> counterValue_r == $past(counterValue_r) + 16'h0001)
    else $error("Counter did not advance on the divided clock");

  hold_no_tick_a: assert property (
    !cntTick && !forceRestart && !wrEn |=> $stable(counterValue_r))
    else $error("Counter moved without a divided clock");

  force_restart_a: assert property (forceUpdateBit |=> counterValue_r == 16'h0000)
    else $error("Forced update did not restart the counter");

  direct_write_a: assert property (
    wrCntL && !forceRestart |=> counterValue_r[7:0] == $past(wrData))
    else $error("Counter low byte write not applied directly");

  urs_hides_flag_a: assert property (
    forceUpdateBit && updateRequestSourceSelect && !wrapHit && !triggerEvent && !updateInhibit
    && !updateFlag_r |=> !updateFlag_r && updateEvent_r)
    else $error("Forced update set the flag under source select");

  update_sets_flag_a: assert property (
    updateNow && !updateRequestSourceSelect |=> updateFlag_r && updateEvent_r)
    else $error("Update event did not set the flag");

  low_latch_a: assert property (
    sHighRead ##1 sLowReadLater |=> rdData_r == $past(lowLatch_r))
    else $error("Low byte read after high read not from the latch");

  psc_low_commit_a: assert property (
    wrPscL |=> pscPreload_r == {$past(pscHold_r), $past(wrData)})
    else $error("Prescaler word not taken on the low byte write");

  psc_read_preload_a: assert property (
    rdEn && regSel == ATBT_PSCL |=> rdData_r == $past(pscPreload_r[7:0]))
    else $error("Prescaler read did not return the preload");

  psc_applies_late_a: assert property (
    wrPscL && !updateNow |=> pscDivision == $past(pscDivision))
    else $error("New prescaler applied before an update event");

  arr_event_copy_a: assert property (
    updateNow && !arrBlocked && !wrArrL |=> arrShadow == $past(arrPreload))
    else $error("Update event did not copy the reload preload");

endmodule // atbt_core

// ===== atbt_pkg.sv
// Types shared by the timer time base modules.
// Assumes the constants header is on the include path.
`include "atbt_consts.svh"

package atbt_pkg;

  // Byte register selected by a read or a write
  typedef enum logic [2:0] {
    ATBT_CNTH = `ATBT_SEL_CNTH,
    ATBT_CNTL = `ATBT_SEL_CNTL,
    ATBT_PSCH = `ATBT_SEL_PSCH,
    ATBT_PSCL = `ATBT_SEL_PSCL,
    ATBT_ARRH = `ATBT_SEL_ARRH,
    ATBT_ARRL = `ATBT_SEL_ARRL,
    ATBT_RCR  = `ATBT_SEL_RCR,
    ATBT_NONE = 3'h7
  } atbt_sel_t;

endpackage

// ===== atbt_prescaler.sv
// Prescaler of the time base: division buffer and internal tick counter.
// Assumes one clock, enables from the same domain, preload held by the parent.
`include "atbt_consts.svh"

module atbt_prescaler #(
  parameter int PSC_W = `ATBT_CNT_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             countEnable,
  input  wire logic             restart,
  input  wire logic             reloadBuffer,
  input  wire logic [PSC_W-1:0] preloadValue,
  output logic                  counterTick,
  output logic      [PSC_W-1:0] divisionValue
);

  logic [PSC_W-1:0] tickCount_r;
  logic [PSC_W-1:0] tickCount_nxt;
  logic [PSC_W-1:0] divBuf_r;

  if (PSC_W < 1 || PSC_W > 32) begin : gWidthCheck
    $error("atbt_prescaler: PSC_W must lie in 1..32");
  end

  // One divided-clock enable each time the count reaches the buffered value
  assign counterTick   = countEnable && !restart && (tickCount_r == divBuf_r);
  assign tickCount_nxt = restart     ? '0 :
                         counterTick ? '0 :
                         countEnable ? tickCount_r + 1'b1 : tickCount_r;
  assign divisionValue = divBuf_r;

  // Tick counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) tickCount_r <= '0;
    else     tickCount_r <= tickCount_nxt;
  end

  // Division buffer follows the preload only at an update event
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)               divBuf_r <= '0;
    else if (reloadBuffer) divBuf_r <= preloadValue;
  end

  default clocking cbP @(posedge ref_clk); endclocking
  default disable iff (rst);

  psc_buffer_hold_a: assert property (!reloadBuffer |=> divBuf_r == $past(divBuf_r))
    else $error("Division buffer changed without an update event");
  psc_restart_zero_a: assert property (restart |=> tickCount_r == '0)
    else $error("Prescaler count did not restart from zero");
  psc_tick_period_a: assert property (counterTick |=> tickCount_r == '0)
    else $error("Prescaler count did not wrap after a tick");

endmodule // atbt_prescaler

// ===== atbt_reload.sv
// Auto-reload value: byte-wise preload, shadow copy and transfer blocking.
// Assumes byte strobes and update event come from logic on the same clock.
`include "atbt_consts.svh"

module atbt_reload (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        preloadEnable,
  input  wire logic        writeHigh,
  input  wire logic        writeLow,
  input  wire logic [7:0]  wrData,
  input  wire logic        updateEvent,
  output logic      [15:0] preloadValue,
  output logic      [15:0] shadowValue,
  output logic             transferBlocked
);

  logic [7:0]  holdHigh_r;
  logic [15:0] preload_r;
  logic [15:0] shadow_r;
  logic        blocked_r;
  logic [15:0] fullWrite;
  logic        directLoad;
  logic        eventLoad;

  // Decode of the two load paths into the shadow copy
  assign fullWrite  = {holdHigh_r, wrData};
  assign directLoad = writeLow && !preloadEnable;
  assign eventLoad  = updateEvent && !blocked_r && !writeLow;

  // High byte waits in a holding byte and blocks the transfer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      holdHigh_r <= 8'(`ATBT_ARR_RST >> `ATBT_HI_LSB);
      blocked_r  <= 1'b0;
    end else if (writeHigh) begin
      holdHigh_r <= wrData;
      blocked_r  <= 1'b1;
    end else if (writeLow) begin
      blocked_r  <= 1'b0;
    end
  end

  // Preload register takes the whole word on the low byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)           preload_r <= `ATBT_ARR_RST;
    else if (writeLow) preload_r <= fullWrite;
  end

  // Shadow copy used by the counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)             shadow_r <= `ATBT_ARR_RST;
    else if (directLoad) shadow_r <= fullWrite;
    else if (eventLoad)  shadow_r <= preload_r;
  end

  assign preloadValue    = preload_r;
  assign shadowValue     = shadow_r;
  assign transferBlocked = blocked_r;

  default clocking cbR @(posedge ref_clk); endclocking
  default disable iff (rst);

  arr_direct_load_a: assert property (writeLow && !preloadEnable
                                      |=> shadow_r == $past(fullWrite))
    else $error("Reload shadow not loaded at once with preload off");
  arr_preload_wait_a: assert property (writeLow && preloadEnable && !updateEvent
                                       |=> shadow_r == $past(shadow_r))
    else $error("Reload shadow changed before an update event");
  arr_block_a: assert property (blocked_r && !writeLow && !directLoad
                                |=> shadow_r == $past(shadow_r))
    else $error("Reload shadow changed while a word write is half done");

endmodule // atbt_reload
